/* add_and_bitop_map.svh */
// opcode codes, field sizes and flag reset values for the execute block
// assumes inclusion by bare name from the package and the module
`ifndef ADD_AND_BITOP_MAP_SVH
`define ADD_AND_BITOP_MAP_SVH
`define ADDR_W 7
`define DATA_W 8
`define BITPOS_W 3
`define NIBBLE_MSB 3
`define WORK_RESET 8'h00
`define DATA_RESET 8'h00
`define ADDR_RESET 7'h00
`define PULSE_IDLE 1'b0
`define ZERO_BYTE 8'h00
`define LSB_ONE 8'h01
`define FLAG_RESET 1'b0
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`define OP_NONE 4'h0
`define OP_ADD_WITH_CARRY_REG 4'h1
`define OP_ADD_REG 4'h2
`define OP_ADD_IMM_WITH_CARRY 4'h3
`define OP_ADD_IMM 4'h4
`define OP_AND_REG 4'h5
`define OP_AND_IMM 4'h6
`define OP_BIT_CLEAR 4'h7
`define OP_BIT_SET 4'h8
`endif

/* add_and_bitop_pkg.sv */
// types used by the execute block; the testbench declares plain logic vectors
// assumes the map header is on the include path
`include "add_and_bitop_map.svh"
package add_and_bitop_pkg;
    typedef logic [3:0] opcode_t;
    typedef logic [`DATA_W-1:0] byte_t;
    typedef logic [`ADDR_W-1:0] faddr_t;
endpackage : add_and_bitop_pkg

/* add_and_bitop_execute.sv */
// single-cycle execute stage for add, and, bit set and bit clear
// assumes a decoder presents one instruction per ref_clk with opValid,
// and a file-register store that returns fileData for fileAddr combinationally
// the store applies fileWrite itself; nothing is forwarded here
`timescale 1ns/1ps
`default_nettype none
`include "add_and_bitop_map.svh"

// Overview of operation
// - adds file, working register and carry to destination; sets zero, nibble, carry flags
// - destination bit 0 writes working register, 1 writes file register back
// - file operand is a 7-bit address 0..127; destination is one bit
// - add reg: working + file without carry in, to destination; zero, nibble, carry flags
// - add imm with carry: working + immediate + carry to working; zero, nibble, carry flags
// - add imm: working + immediate to working; zero, nibble, carry flags; one cycle
// - and reg: working AND file to destination, only zero flag, one cycle
// - and imm: working AND immediate to working, only zero flag, one cycle
// - bit clear: zero selected bit 0..7 of file register, flags kept, one cycle
// - bit set: one selected bit 0..7 of file register, flags kept, one cycle
// - addition sets carry on carry out of bit 7, clears otherwise
// - nibble overflow flag kept beside carry and zero, updated by additions
module add_and_bitop_execute (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic opValid,
    input wire add_and_bitop_pkg::opcode_t opcode,
    input wire add_and_bitop_pkg::faddr_t fileAddr,
    input wire logic destSel,
    input wire logic [`BITPOS_W-1:0] bitPos,
    input wire add_and_bitop_pkg::byte_t immData,
    input wire add_and_bitop_pkg::byte_t fileData,
    output logic fileWrite,
    output add_and_bitop_pkg::faddr_t fileWriteAddr,
    output add_and_bitop_pkg::byte_t fileWriteData,
    output add_and_bitop_pkg::byte_t working_register,
    output logic carryFlag,
    output logic nibble_overflow_flag,
    output logic zeroFlag,
    output logic opDone
);
    typedef enum {ADD_KIND, AND_KIND, BIT_KIND, NO_KIND} kind_t;

    // sum with carry outs of bit 3 and bit 7
    function automatic logic [`DATA_W+1:0] add3(input add_and_bitop_pkg::byte_t a,
                                               input add_and_bitop_pkg::byte_t b, input logic cin);
        logic [`NIBBLE_MSB+1:0] low;
        logic [`DATA_W:0] full;
        low = {1'b0, a[`NIBBLE_MSB:0]} + {1'b0, b[`NIBBLE_MSB:0]} + (`NIBBLE_MSB+2)'(cin);
        full = {1'b0, a} + {1'b0, b} + (`DATA_W+1)'(cin);
        add3 = {full[`DATA_W], low[`NIBBLE_MSB+1], full[`DATA_W-1:0]};
    endfunction : add3

    // true when a result byte is all zeros
    function automatic logic is_zero(input add_and_bitop_pkg::byte_t v);
        is_zero = (v == `ZERO_BYTE);
    endfunction : is_zero

    // one-hot mask for a bit position inside a byte
    function automatic add_and_bitop_pkg::byte_t bit_mask(input logic [`BITPOS_W-1:0] pos);
        bit_mask = `LSB_ONE << pos;
    endfunction : bit_mask

    add_and_bitop_pkg::byte_t next_working_register;
    add_and_bitop_pkg::byte_t next_fileWriteData;
    add_and_bitop_pkg::byte_t result;
    add_and_bitop_pkg::byte_t operandB;
    add_and_bitop_pkg::faddr_t next_fileWriteAddr;
    logic [`DATA_W+1:0] sum;
    logic next_fileWrite;
    logic next_carryFlag;
    logic next_nibble_overflow_flag;
    logic next_zeroFlag;
    logic next_opDone;
    logic useCarry;
    logic toFile;
    kind_t kind;

    always_comb begin
        kind = NO_KIND;
        useCarry = 1'b0;
        toFile = 1'b0;
        operandB = fileData;
        case (opcode)
            `OP_ADD_WITH_CARRY_REG: begin
                kind = ADD_KIND;
                useCarry = 1'b1;
                toFile = (destSel == `DEST_FILE);
            end
            `OP_ADD_REG: begin
                kind = ADD_KIND;
                toFile = (destSel == `DEST_FILE);
            end
            `OP_ADD_IMM_WITH_CARRY: begin
                kind = ADD_KIND;
                useCarry = 1'b1;
                operandB = immData;
            end
            `OP_ADD_IMM: begin
                kind = ADD_KIND;
                operandB = immData;
            end
            `OP_AND_REG: begin
                kind = AND_KIND;
                toFile = (destSel == `DEST_FILE);
            end
            `OP_AND_IMM: begin
                kind = AND_KIND;
                operandB = immData;
            end
            `OP_BIT_CLEAR, `OP_BIT_SET: begin
                kind = BIT_KIND;
                toFile = 1'b1;
            end
            default: begin
                kind = NO_KIND;
            end
        endcase
        if (!opValid) begin
            kind = NO_KIND;
        end
    end

    // sum and result byte of the current instruction
    always_comb begin
        sum = add3(working_register, operandB, useCarry & carryFlag);
        result = fileData;
        case (kind)
            ADD_KIND: begin
                result = sum[`DATA_W-1:0];
            end
            AND_KIND: begin
                result = working_register & operandB;
            end
            BIT_KIND: begin
                if (opcode == `OP_BIT_SET) begin
                    result = fileData | bit_mask(bitPos);
                end else begin
                    result = fileData & ~bit_mask(bitPos);
                end
            end
            default: begin
                result = fileData;
            end
        endcase
    end

    // working register group
    always_comb begin
        next_working_register = working_register;
        if (kind != NO_KIND && !toFile) begin
            next_working_register = result;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            working_register <= `WORK_RESET;
        end else begin
            working_register <= next_working_register;
        end
    end

    // status flags: adds set all three, ands only zero, bit ops none
    always_comb begin
        next_carryFlag = carryFlag;
        next_nibble_overflow_flag = nibble_overflow_flag;
        next_zeroFlag = zeroFlag;
        case (kind)
            ADD_KIND: begin
                next_carryFlag = sum[`DATA_W+1];
                next_nibble_overflow_flag = sum[`DATA_W];
                next_zeroFlag = is_zero(result);
            end
            AND_KIND: begin
                next_zeroFlag = is_zero(result);
            end
            default: begin
                next_zeroFlag = zeroFlag;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            carryFlag <= `FLAG_RESET;
            nibble_overflow_flag <= `FLAG_RESET;
            zeroFlag <= `FLAG_RESET;
        end else begin
            carryFlag <= next_carryFlag;
            nibble_overflow_flag <= next_nibble_overflow_flag;
            zeroFlag <= next_zeroFlag;
        end
    end

    // write-back port: one-cycle strobe, address and data hold between writes
    always_comb begin
        next_fileWrite = `PULSE_IDLE;
        next_fileWriteAddr = fileWriteAddr;
        next_fileWriteData = fileWriteData;
        if (kind != NO_KIND && toFile) begin
            next_fileWrite = 1'b1;
            next_fileWriteAddr = fileAddr;
            next_fileWriteData = result;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            fileWrite <= `PULSE_IDLE;
            fileWriteAddr <= `ADDR_RESET;
            fileWriteData <= `DATA_RESET;
        end else begin
            fileWrite <= next_fileWrite;
            fileWriteAddr <= next_fileWriteAddr;
            fileWriteData <= next_fileWriteData;
        end
    end

    // one done pulse per accepted instruction
    always_comb begin
        next_opDone = (kind != NO_KIND);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            opDone <= `PULSE_IDLE;
        end else begin
            opDone <= next_opDone;
        end
    end
endmodule : add_and_bitop_execute
`default_nettype wire

/* add_and_bitop_execute_monitor.sv */
// assertions on the execute block ports
// assumes the execute module is compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "add_and_bitop_map.svh"
module add_and_bitop_execute_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic opValid,
    input wire logic [3:0] opcode,
    input wire logic [6:0] fileAddr,
    input wire logic destSel,
    input wire logic [2:0] bitPos,
    input wire logic [7:0] immData,
    input wire logic [7:0] fileData,
    input wire logic fileWrite,
    input wire logic [6:0] fileWriteAddr,
    input wire logic [7:0] fileWriteData,
    input wire logic [7:0] working_register,
    input wire logic carryFlag,
    input wire logic nibble_overflow_flag,
    input wire logic zeroFlag,
    input wire logic opDone
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    done_pulse_a: assert property (
        opDone == $past(opValid && opcode inside {`OP_ADD_WITH_CARRY_REG, `OP_ADD_REG, `OP_ADD_IMM_WITH_CARRY,
        `OP_ADD_IMM, `OP_AND_REG, `OP_AND_IMM, `OP_BIT_CLEAR, `OP_BIT_SET})) else $error("done pulse wrong");
    adc_file_a: assert property (opValid && opcode == `OP_ADD_WITH_CARRY_REG && destSel |=>
        fileWrite && fileWriteAddr == $past(fileAddr) &&
        fileWriteData == $past(8'(fileData + working_register + carryFlag))) else $error("adc to file wrong");
    add_reg_work_a: assert property (opValid && opcode == `OP_ADD_REG && !destSel |=> !fileWrite &&
        working_register == $past(8'(working_register + fileData))) else $error("add to working wrong");
    add_carry_a: assert property (opValid && opcode == `OP_ADD_IMM |=>
        {carryFlag, working_register} == $past(9'(working_register) + immData)) else $error("carry wrong");
    adci_nibble_a: assert property (opValid && opcode == `OP_ADD_IMM_WITH_CARRY |=>
        nibble_overflow_flag == $past(5'(working_register[3:0]) + immData[3:0] + carryFlag > 5'h0f))
        else $error("nibble wrong");
    and_imm_zero_a: assert property (opValid && opcode == `OP_AND_IMM |=> $stable(carryFlag) &&
        zeroFlag == $past((working_register & immData) == 8'h00)) else $error("and zero wrong");
    and_reg_file_a: assert property (opValid && opcode == `OP_AND_REG && destSel |=>
        $stable(working_register) && fileWriteData == $past(working_register & fileData))
        else $error("and to file wrong");
    bit_op_a: assert property (opValid && opcode inside {`OP_BIT_CLEAR, `OP_BIT_SET} |=>
        fileWrite && $stable({carryFlag, nibble_overflow_flag, zeroFlag}) &&
        fileWriteData == $past(opcode == `OP_BIT_SET ? fileData | (8'h01 << bitPos) : fileData & ~(8'h01 << bitPos)))
        else $error("bit op wrong");
endmodule : add_and_bitop_execute_monitor
bind add_and_bitop_execute add_and_bitop_execute_monitor monitor (
    .ref_clk(ref_clk),
    .reset(reset),
    .opValid(opValid),
    .opcode(opcode),
    .fileAddr(fileAddr),
    .destSel(destSel),
    .bitPos(bitPos),
    .immData(immData),
    .fileData(fileData),
    .fileWrite(fileWrite),
    .fileWriteAddr(fileWriteAddr),
    .fileWriteData(fileWriteData),
    .working_register(working_register),
    .carryFlag(carryFlag),
    .nibble_overflow_flag(nibble_overflow_flag),
    .zeroFlag(zeroFlag),
    .opDone(opDone)
);
`default_nettype wire

/* add_and_bitop_execute_tb_top.sv */
// self-checking bench for the execute block
// assumes package and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "add_and_bitop_map.svh"
module add_and_bitop_execute_tb_top;
    logic ref_clk = 1'b0, reset = 1'b1, opValid = 1'b0, destSel = 1'b0;
    logic expCarry = 1'b0, expNibble = 1'b0, expZero = 1'b0;
    logic fileWrite, carryFlag, nibble_overflow_flag, zeroFlag, opDone;
    logic [3:0] opcode = 4'h0;
    logic [6:0] fileAddr = 7'h00, fileWriteAddr;
    logic [2:0] bitPos = 3'h0;
    logic [7:0] immData = 8'h00, fileData = 8'h00, fileWriteData, working_register, expWork = 8'h00;
    int err_total = 0, check_count = 0;
    add_and_bitop_execute DUT (
        .ref_clk(ref_clk),
        .reset(reset),
        .opValid(opValid),
        .opcode(opcode),
        .fileAddr(fileAddr),
        .destSel(destSel),
        .bitPos(bitPos),
        .immData(immData),
        .fileData(fileData),
        .fileWrite(fileWrite),
        .fileWriteAddr(fileWriteAddr),
        .fileWriteData(fileWriteData),
        .working_register(working_register),
        .carryFlag(carryFlag),
        .nibble_overflow_flag(nibble_overflow_flag),
        .zeroFlag(zeroFlag),
        .opDone(opDone)
    );
    initial forever #10 ref_clk = ~ref_clk;
    task chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    task ex(input logic [3:0] o, input logic d, input logic [2:0] b, input logic [7:0] im, input logic [7:0] fd);
        logic [7:0] p, r;
        logic ci, w, regOp, bitOp, addOp, andOp;
        regOp = o inside {`OP_ADD_WITH_CARRY_REG, `OP_ADD_REG, `OP_AND_REG};
        bitOp = o inside {`OP_BIT_CLEAR, `OP_BIT_SET};
        addOp = o inside {`OP_ADD_WITH_CARRY_REG, `OP_ADD_REG, `OP_ADD_IMM_WITH_CARRY, `OP_ADD_IMM};
        andOp = o inside {`OP_AND_REG, `OP_AND_IMM};
        opValid = 1'b1;
        opcode = o;
        destSel = d;
        bitPos = b;
        immData = im;
        fileData = fd;
        fileAddr = {b, o};
        p = regOp ? fd : im;
        ci = (o == `OP_ADD_WITH_CARRY_REG || o == `OP_ADD_IMM_WITH_CARRY) && expCarry;
        w = regOp ? d : bitOp;
        r = addOp ? 8'(expWork + p + ci) : andOp ? (expWork & p) :
            (o == `OP_BIT_CLEAR) ? (fd & ~(8'h01 << b)) : (fd | (8'h01 << b));
        if (addOp) begin
            expNibble = (5'(expWork[3:0]) + p[3:0] + ci) > 5'h0f;
            expCarry = (9'(expWork) + p + ci) > 9'h0ff;
        end
        if (addOp || andOp) expZero = (r == 8'h00);
        if ((addOp || andOp) && !w) expWork = r;
        @(negedge ref_clk);
        chk(opDone === (addOp || andOp || bitOp), "done pulse");
        chk(fileWrite === w, "write strobe");
        chk(!w || (fileWriteData === r && fileWriteAddr === {b, o}), "write back");
        chk(working_register === expWork, "working register");
        chk({carryFlag, nibble_overflow_flag, zeroFlag} === {expCarry, expNibble, expZero}, "flags");
    endtask : ex
    task t_add;
        ex(`OP_ADD_IMM, 1'b0, 3'h0, 8'h12, 8'h00);
        ex(`OP_ADD_REG, 1'b1, 3'h0, 8'h00, 8'hee);
        ex(`OP_ADD_WITH_CARRY_REG, 1'b1, 3'h0, 8'h00, 8'h34);
        ex(`OP_ADD_REG, 1'b1, 3'h0, 8'h00, 8'hee);
        ex(`OP_ADD_IMM_WITH_CARRY, 1'b0, 3'h0, 8'h34, 8'h00);
        ex(`OP_ADD_REG, 1'b0, 3'h0, 8'h00, 8'hb9);
        ex(`OP_ADD_WITH_CARRY_REG, 1'b0, 3'h0, 8'h00, 8'hff);
        ex(`OP_ADD_IMM, 1'b1, 3'h0, 8'h0f, 8'h00);
        $display("add test done");
    endtask : t_add
    task t_logic;
        ex(`OP_ADD_IMM, 1'b0, 3'h0, 8'h4b, 8'h00);
        ex(`OP_AND_REG, 1'b1, 3'h0, 8'h00, 8'haf);
        ex(`OP_AND_REG, 1'b0, 3'h0, 8'h00, 8'ha5);
        ex(`OP_ADD_IMM, 1'b0, 3'h0, 8'h5a, 8'h00);
        ex(`OP_AND_IMM, 1'b0, 3'h0, 8'haf, 8'h00);
        ex(`OP_BIT_CLEAR, 1'b0, 3'h3, 8'h00, 8'h5a);
        ex(`OP_BIT_CLEAR, 1'b1, 3'h0, 8'h00, 8'hff);
        ex(`OP_BIT_SET, 1'b0, 3'h2, 8'h00, 8'h5a);
        ex(`OP_BIT_SET, 1'b1, 3'h7, 8'h00, 8'h00);
        $display("logic test done");
    endtask : t_logic
    task t_refuse;
        ex(`OP_NONE, 1'b1, 3'h1, 8'hff, 8'hff);
        ex(4'hf, 1'b1, 3'h7, 8'hff, 8'hff);
        opValid = 1'b0;
        opcode = `OP_ADD_WITH_CARRY_REG;
        @(negedge ref_clk);
        chk(opDone === 1'b0 && fileWrite === 1'b0 && working_register === expWork, "idle cycle");
        chk({carryFlag, nibble_overflow_flag, zeroFlag} === {expCarry, expNibble, expZero}, "idle flags");
        $display("refuse test done");
    endtask : t_refuse
    task summarize;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        t_add;
        t_logic;
        t_refuse;
        summarize;
    end
endmodule : add_and_bitop_execute_tb_top
`default_nettype wire
